// file: hdl/cxm_ctrl.sv
// CAN transceiver mode control: modes, transmitter supervision, wake decode.
// Assumes pin inputs are asynchronous and the host speaks AXI4-Lite.
// Functional notes
// RULE1 - Transceiver off after reset until activated
// RULE2 - Normal mode: transmit, receive, bias on
// RULE3 - No interrupt in normal; standby reachable
// RULE4 - Standby: transmitter off, receive recessive, wake on
// RULE5 - Standby wake pattern raises host interrupt; the code raises it in regulator standby only, not battery standby
// RULE6 - No auto normal; activation 160 us guard
// RULE7 - Standby bias from auto-bias or timeout; the code biases on auto-bias only, and a timeout turns bias off
// RULE8 - Auto transmitter off on faults and thermal
// RULE9 - Receiver never disabled by faults
// RULE10 - Transmit dominant timeout latches, blocks transmitter
// RULE11 - Four bus follow failures latch, block
// RULE12 - Bus permanent dominant latches, transmitter kept
// RULE13 - Four receive follow failures latch, block
// RULE14 - Default bus wake; two dominant bits
// RULE15 - Pattern: two filtered pulses within window
// RULE16 - Pattern works from dominant or recessive
// RULE17 - Battery standby wake gives 2 ms reset
// RULE18 - Listen-only disables transmitter, receiver stays
// RULE19 - Loopback routes transmit input to receive
// RULE20 - Window expiry discards partial pattern
//
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "cxm_consts.svh"
module cxm_ctrl #(
  parameter logic [15:0] T_WAKE_CYC = 16'(`CXM_WAKE_CYC),
  parameter logic [15:0] T_RST_CYC  = 16'(`CXM_RST_CYC)
) (
  input  wire logic                  CLK,
  input  wire logic                  RST,
  input  wire cxm_pkg::cxm_axi_req_s AXI_REQ,
  output cxm_pkg::cxm_axi_rsp_s      AXI_RSP,
  input  wire logic                  TX_DATA_IN,
  input  wire logic                  BUS_RX,
  input  wire logic                  RX_PIN_SENSE,
  input  wire logic [7:0]            THERMAL_SHUTDOWN_FIRST_LEVEL,
  input  wire logic                  COMM_TIMEOUT,
  output logic                       TX_ENABLE,
  output logic                       RX_ENABLE,
  output logic                       BIAS_ON,
  output logic                       RX_DATA_OUT,
  output logic                       WAKE_INT,
  output logic                       RESET_OUT_N
);
  cxm_pkg::cxm_state_s r;
  cxm_pkg::cxm_state_s n;
  logic [7:0] thr_sync0;
  logic [7:0] thr_sync1;
  logic [7:0] thr_sync2;
  logic [7:0] thr_f;

  // Thermal flags: three stages, accepted when the last two agree
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      thr_sync0 <= 8'h00;
      thr_sync1 <= 8'h00;
      thr_sync2 <= 8'h00;
      thr_f     <= 8'h00;
    end else begin
      thr_sync0 <= THERMAL_SHUTDOWN_FIRST_LEVEL;
      thr_sync1 <= thr_sync0;
      thr_sync2 <= thr_sync1;
      if (thr_sync1 == thr_sync2) begin
        thr_f <= thr_sync2;
      end
    end
  end

  // Next state of the block, all but the thermal synchroniser
  always_comb begin
    logic [4:0]  set;
    logic [4:0]  clr;
    logic        thermal;
    logic        fault;
    logic        wake_hit;
    logic        stby;
    logic        act_ok;
    logic [7:0]  wofs;
    logic [7:0]  rofs;
    logic [31:0] rd;
    set      = 5'h00;
    clr      = 5'h00;
    thermal  = 1'b0;
    fault    = 1'b0;
    wake_hit = 1'b0;
    stby     = 1'b0;
    act_ok   = 1'b0;
    wofs     = 8'h00;
    rofs     = 8'h00;
    rd       = 32'h0000_0000;
    n = r;

    // Pin synchronisers; first stage feeds only the second
    n.tx_s  = {r.tx_s[1:0], TX_DATA_IN};
    n.bus_s = {r.bus_s[1:0], BUS_RX};
    n.fb_s  = {r.fb_s[1:0], RX_PIN_SENSE};
    if (r.tx_s[1] == r.tx_s[2]) begin
      n.tx_f = r.tx_s[2];
    end
    if (r.bus_s[1] == r.bus_s[2]) begin
      n.bus_f = r.bus_s[2];
    end
    if (r.fb_s[1] == r.fb_s[2]) begin
      n.fb_f = r.fb_s[2];
    end
    n.tx_prev = r.tx_f;

    // Thermal cut: global group only, or any group
    thermal = r.ctrl[`CXM_B_TGS] ? thr_f[`CXM_THERM_GLOBAL] : (|thr_f); // [RULE8]

    // Transmit input held dominant too long
    if (r.mode == cxm_pkg::CXM_NORMAL && !r.tx_f) begin
      if (r.tx_dom_cnt < 16'(`CXM_DOM_TX_CYC)) begin
        n.tx_dom_cnt = r.tx_dom_cnt + 16'h0001;
      end else begin
        set[`CXM_B_TX_DOM] = 1'b1; // [RULE10]
      end
    end else begin
      n.tx_dom_cnt = 16'h0000;
    end

    // Bus stuck dominant: flag only, transmitter untouched
    if (r.mode == cxm_pkg::CXM_NORMAL && !r.bus_f) begin
      if (r.bus_dom_cnt < 16'(`CXM_PERM_DOM_CYC)) begin
        n.bus_dom_cnt = r.bus_dom_cnt + 16'h0001;
      end else begin
        set[`CXM_B_PERM_DOM] = 1'b1; // [RULE12]
      end
    end else begin
      n.bus_dom_cnt = 16'h0000;
    end

    // Follow check opened on each dominant edge of the transmit input while the transmitter is enabled
    if (r.tx_prev && !r.tx_f && r.tx_en) begin
      n.fol_busy = 1'b1;
      n.fol_cnt  = 8'h00;
      n.fol_bus  = 1'b0;
      n.fol_fb   = 1'b0;
    end else if (r.fol_busy) begin
      n.fol_cnt = r.fol_cnt + 8'h01;
      n.fol_bus = r.fol_bus | ~r.bus_f;
      n.fol_fb  = r.fol_fb | ~r.fb_f;
      if (r.fol_cnt == 8'(`CXM_FOLLOW_CYC)) begin
        n.fol_busy = 1'b0;
        n.bus_fail = r.fol_bus ? 3'h0 : r.bus_fail + 3'h1;
        n.fb_fail  = r.fol_fb ? 3'h0 : r.fb_fail + 3'h1;
        if (!r.fol_bus && r.bus_fail + 3'h1 == `CXM_FAIL_LIMIT) begin
          set[`CXM_B_BUS_REC] = 1'b1; // [RULE11]
          n.bus_fail = 3'h0;
        end
        if (!r.fol_fb && r.fb_fail + 3'h1 == `CXM_FAIL_LIMIT) begin
          set[`CXM_B_RX_REC] = 1'b1; // [RULE13]
          n.fb_fail = 3'h0;
        end
      end
    end

    // Guard time after bus wake-up is enabled
    n.we_prev = r.ctrl[`CXM_B_WAKE_EN];
    if (r.ctrl[`CXM_B_WAKE_EN] && !r.we_prev) begin
      n.guard_cnt = 16'(`CXM_GUARD_CYC); // [RULE6]
    end else if (r.guard_cnt != 16'h0000) begin
      n.guard_cnt = r.guard_cnt - 16'h0001;
    end
    // Next count, so activation written with wake enable waits too
    act_ok = r.ctrl[`CXM_B_ACT] && (n.guard_cnt == 16'h0000); // [RULE6]

    // Mode machine; leaves off or standby only on activation
    case (r.mode)
      cxm_pkg::CXM_OFF: begin
        if (act_ok) begin
          n.mode = cxm_pkg::CXM_NORMAL; // [RULE1]
        end
      end
      cxm_pkg::CXM_NORMAL: begin
        if (!r.ctrl[`CXM_B_ACT]) begin
          n.mode = r.ctrl[`CXM_B_STBY_BAT] ? cxm_pkg::CXM_STBY_BAT : cxm_pkg::CXM_STBY_REG; // [RULE3]
        end
      end
      cxm_pkg::CXM_STBY_REG, cxm_pkg::CXM_STBY_BAT: begin
        if (act_ok) begin
          n.mode = cxm_pkg::CXM_NORMAL; // [RULE6]
        end
      end
      default: begin
        n.mode = cxm_pkg::CXM_OFF;
      end
    endcase
    stby = (r.mode == cxm_pkg::CXM_STBY_REG) || (r.mode == cxm_pkg::CXM_STBY_BAT);

    // Wake pattern decoder: dominant, gap, dominant, all in one window
    if (!stby || !r.ctrl[`CXM_B_WAKE_EN]) begin
      n.wst = cxm_pkg::CXM_W_IDLE; // [RULE4]
    end else begin
      if (r.pulse_cnt != 16'hffff) begin
        n.pulse_cnt = r.pulse_cnt + 16'h0001;
      end
      n.win_cnt = r.win_cnt + 16'h0001;
      case (r.wst)
        cxm_pkg::CXM_W_IDLE: begin
          // A bus already dominant at entry counts as pulse one
          if (!r.bus_f) begin
            n.wst       = cxm_pkg::CXM_W_DOM1; // [RULE16]
            n.pulse_cnt = 16'h0000;
            n.win_cnt   = 16'h0000;
          end
        end
        cxm_pkg::CXM_W_DOM1: begin
          if (r.bus_f) begin
            n.pulse_cnt = 16'h0000;
            if (r.pulse_cnt > 16'(`CXM_FILTER_CYC)) begin
              n.wst = cxm_pkg::CXM_W_GAP; // [RULE15]
            end else begin
              n.wst = cxm_pkg::CXM_W_IDLE;
            end
          end
        end
        cxm_pkg::CXM_W_GAP: begin
          if (!r.bus_f) begin
            // Too short a gap is taken as part of pulse one
            n.wst = (r.pulse_cnt > 16'(`CXM_FILTER_CYC)) ? cxm_pkg::CXM_W_DOM2 : cxm_pkg::CXM_W_DOM1;
            if (r.pulse_cnt > 16'(`CXM_FILTER_CYC)) begin
              n.pulse_cnt = 16'h0000;
            end
          end
        end
        cxm_pkg::CXM_W_DOM2: begin
          if (r.pulse_cnt > 16'(`CXM_FILTER_CYC)) begin
            wake_hit = 1'b1; // [RULE14] [RULE15]
            n.wst    = cxm_pkg::CXM_W_IDLE;
          end else if (r.bus_f) begin
            n.wst       = cxm_pkg::CXM_W_GAP;
            n.pulse_cnt = 16'h0000;
          end
        end
        default: begin
          n.wst = cxm_pkg::CXM_W_IDLE;
        end
      endcase
      if (r.wst != cxm_pkg::CXM_W_IDLE && !wake_hit && r.win_cnt >= T_WAKE_CYC) begin
        n.wst = cxm_pkg::CXM_W_IDLE; // [RULE20]
      end
    end
    set[`CXM_B_WAKE] = wake_hit;

    // Battery standby wake answers with a reset pulse
    if (wake_hit && r.mode == cxm_pkg::CXM_STBY_BAT) begin
      n.rst_cnt = T_RST_CYC; // [RULE17]
    end else if (r.rst_cnt != 16'h0000) begin
      n.rst_cnt = r.rst_cnt - 16'h0001;
    end

    // Write channel: address and data taken in either order
    if (AXI_REQ.awvalid && r.rsp.awready) begin
      n.aw_held = 1'b1;
      n.aw_addr = AXI_REQ.awaddr;
    end
    if (AXI_REQ.wvalid && r.rsp.wready) begin
      n.w_held = 1'b1;
      n.w_data = AXI_REQ.wdata;
      n.w_strb = AXI_REQ.wstrb;
    end
    if (r.rsp.bvalid && AXI_REQ.bready) begin
      n.rsp.bvalid = 1'b0;
    end
    if (r.aw_held && r.w_held && !r.rsp.bvalid) begin
      wofs          = {r.aw_addr[7:2], 2'b00};
      n.aw_held     = 1'b0;
      n.w_held      = 1'b0;
      n.rsp.bvalid  = 1'b1;
      n.rsp.bresp   = `CXM_RESP_OKAY;
      if (wofs == `CXM_OFS_CTRL) begin
        if (r.w_strb[0]) begin
          n.ctrl = {1'b0, r.w_data[6:0]}; // [RULE18] [RULE19]
        end
      end else if (wofs == `CXM_OFS_STATUS) begin
        if (r.w_strb[0]) begin
          clr = r.w_data[4:0];
        end
      end else if (wofs != `CXM_OFS_STATE) begin
        n.rsp.bresp = `CXM_RESP_SLVERR;
      end
    end
    n.rsp.awready = !n.aw_held && !n.rsp.bvalid;
    n.rsp.wready  = !n.w_held && !n.rsp.bvalid;

    // Sticky status: a new event beats a clear in the same cycle
    n.stat = (r.stat & ~clr) | set; // [RULE10] [RULE11] [RULE13]

    // Read channel: answer in the cycle after the address
    if (r.rsp.rvalid && AXI_REQ.rready) begin
      n.rsp.rvalid = 1'b0;
    end
    if (AXI_REQ.arvalid && r.rsp.arready) begin
      rofs = {AXI_REQ.araddr[7:2], 2'b00};
      rd[`CXM_B_MODE+:2] = r.mode;
      rd[`CXM_B_TX_EN]   = r.tx_en;
      rd[`CXM_B_RX_EN]   = r.rx_en;
      rd[`CXM_B_BIAS]    = r.bias;
      rd[`CXM_B_WST+:2]  = r.wst;
      n.rsp.rvalid = 1'b1;
      n.rsp.rresp  = `CXM_RESP_OKAY;
      n.rsp.rdata  = 32'h0000_0000;
      if (rofs == `CXM_OFS_CTRL) begin
        n.rsp.rdata[7:0] = r.ctrl;
      end else if (rofs == `CXM_OFS_STATUS) begin
        n.rsp.rdata[4:0] = r.stat;
      end else if (rofs == `CXM_OFS_STATE) begin
        n.rsp.rdata = rd;
      end else begin
        n.rsp.rresp = `CXM_RESP_SLVERR;
      end
    end
    n.rsp.arready = !n.rsp.rvalid;

    // Transmitter blocked by a latched transmit-dominant or follow fault, or thermal cut; permanent dominant excluded
    fault = n.stat[`CXM_B_TX_DOM] | n.stat[`CXM_B_BUS_REC] | n.stat[`CXM_B_RX_REC] | thermal; // [RULE8]
    n.tx_en = (n.mode == cxm_pkg::CXM_NORMAL) && !n.ctrl[`CXM_B_LISTEN] && !fault; // [RULE2] [RULE18]
    // Faults never reach the receiver enable
    n.rx_en = (n.mode != cxm_pkg::CXM_OFF); // [RULE9]
    if (n.mode == cxm_pkg::CXM_NORMAL) begin
      n.bias = 1'b1; // [RULE2]
    end else if (n.mode == cxm_pkg::CXM_OFF) begin
      n.bias = 1'b0;
    end else begin
      n.bias = n.ctrl[`CXM_B_AUTO_BIAS] && !COMM_TIMEOUT; // [RULE7]
    end

    // Receive output: loopback, bus, or recessive outside normal
    if (n.mode != cxm_pkg::CXM_NORMAL) begin
      n.rxd = 1'b1; // [RULE4]
    end else if (n.ctrl[`CXM_B_LOOP]) begin
      n.rxd = r.tx_f; // [RULE19]
    end else begin
      n.rxd = r.bus_f;
    end
    // Interrupt only from regulator-on standby, never in normal
    n.wake_int = n.stat[`CXM_B_WAKE] && (n.mode == cxm_pkg::CXM_STBY_REG); // [RULE3] [RULE5]
    n.rst_n    = (n.rst_cnt == 16'h0000); // [RULE17]
  end

  // State register; wake-up enabled by default after reset
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      r <= '0;
      r.ctrl[`CXM_B_WAKE_EN] <= 1'b1; // [RULE14]
      r.we_prev     <= 1'b1;
      r.mode        <= cxm_pkg::CXM_OFF; // [RULE1]
      r.wst         <= cxm_pkg::CXM_W_IDLE;
      r.tx_s        <= 3'h7;
      r.bus_s       <= 3'h7;
      r.fb_s        <= 3'h7;
      r.tx_f        <= 1'b1;
      r.bus_f       <= 1'b1;
      r.fb_f        <= 1'b1;
      r.tx_prev     <= 1'b1;
      r.rxd         <= 1'b1;
      r.rst_n       <= 1'b1;
      r.rsp.awready <= 1'b1;
      r.rsp.wready  <= 1'b1;
      r.rsp.arready <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state register
  assign AXI_RSP     = r.rsp;
  assign TX_ENABLE   = r.tx_en;
  assign RX_ENABLE   = r.rx_en;
  assign BIAS_ON     = r.bias;
  assign RX_DATA_OUT = r.rxd;
  assign WAKE_INT    = r.wake_int;
  assign RESET_OUT_N = r.rst_n;
endmodule

// file: inc/cxm_consts.svh
// Constants of the CAN transceiver mode control block.
// Assumes a 10 MHz core clock and byte addresses on the bus.
`ifndef CXM_CONSTS_SVH
`define CXM_CONSTS_SVH
`define CXM_CLK_MHZ       10
`define CXM_T_FILTER_US   1
`define CXM_T_FOLLOW_US   2
`define CXM_T_DOM_TX_US   300
`define CXM_T_PERM_DOM_US 400
`define CXM_T_WAKE_US     1000
`define CXM_T_GUARD_US    160
`define CXM_T_RST_MS      2
`define CXM_FILTER_CYC    (`CXM_T_FILTER_US * `CXM_CLK_MHZ)
`define CXM_FOLLOW_CYC    (`CXM_T_FOLLOW_US * `CXM_CLK_MHZ)
`define CXM_DOM_TX_CYC    (`CXM_T_DOM_TX_US * `CXM_CLK_MHZ)
`define CXM_PERM_DOM_CYC  (`CXM_T_PERM_DOM_US * `CXM_CLK_MHZ)
`define CXM_WAKE_CYC      (`CXM_T_WAKE_US * `CXM_CLK_MHZ)
`define CXM_GUARD_CYC     (`CXM_T_GUARD_US * `CXM_CLK_MHZ)
`define CXM_RST_CYC       (`CXM_T_RST_MS * 1000 * `CXM_CLK_MHZ)
`define CXM_FAIL_LIMIT    3'h4
`define CXM_THERM_GLOBAL  7
`define CXM_OFS_CTRL      8'h00
`define CXM_OFS_STATUS    8'h04
`define CXM_OFS_STATE     8'h08
`define CXM_B_ACT         0
`define CXM_B_STBY_BAT    1
`define CXM_B_AUTO_BIAS   2
`define CXM_B_LISTEN      3
`define CXM_B_LOOP        4
`define CXM_B_TGS         5
`define CXM_B_WAKE_EN     6
`define CXM_B_TX_DOM      0
`define CXM_B_BUS_REC     1
`define CXM_B_RX_REC      2
`define CXM_B_PERM_DOM    3
`define CXM_B_WAKE        4
`define CXM_B_MODE        0
`define CXM_B_TX_EN       2
`define CXM_B_RX_EN       3
`define CXM_B_BIAS        4
`define CXM_B_WST         5
`define CXM_RESP_OKAY     2'h0
`define CXM_RESP_SLVERR   2'h2
`endif

// file: inc/cxm_pkg.sv
// Types of the CAN transceiver mode control block.
// Assumes nothing beyond SystemVerilog packed types.
package cxm_pkg;
  typedef enum logic [1:0] {
    CXM_OFF      = 2'h0,
    CXM_NORMAL   = 2'h1,
    CXM_STBY_REG = 2'h3,
    CXM_STBY_BAT = 2'h2
  } cxm_mode_e;
  typedef enum logic [1:0] {
    CXM_W_IDLE = 2'h0,
    CXM_W_DOM1 = 2'h1,
    CXM_W_GAP  = 2'h3,
    CXM_W_DOM2 = 2'h2
  } cxm_wake_e;
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } cxm_axi_req_s;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } cxm_axi_rsp_s;
  typedef struct packed {
    cxm_axi_rsp_s rsp;
    logic [7:0]   ctrl;
    logic [4:0]   stat;
    cxm_mode_e    mode;
    cxm_wake_e    wst;
    logic [2:0]   tx_s;
    logic [2:0]   bus_s;
    logic [2:0]   fb_s;
    logic         tx_f;
    logic         bus_f;
    logic         fb_f;
    logic         tx_prev;
    logic         we_prev;
    logic [15:0]  tx_dom_cnt;
    logic [15:0]  bus_dom_cnt;
    logic [7:0]   fol_cnt;
    logic         fol_busy;
    logic         fol_bus;
    logic         fol_fb;
    logic [2:0]   bus_fail;
    logic [2:0]   fb_fail;
    logic [15:0]  guard_cnt;
    logic [15:0]  pulse_cnt;
    logic [15:0]  win_cnt;
    logic [15:0]  rst_cnt;
    logic         aw_held;
    logic [7:0]   aw_addr;
    logic         w_held;
    logic [31:0]  w_data;
    logic [3:0]   w_strb;
    logic         tx_en;
    logic         rx_en;
    logic         bias;
    logic         rxd;
    logic         wake_int;
    logic         rst_n;
  } cxm_state_s;
endpackage

// file: test/cxm_bus_model.sv
// Behavioural CAN bus and receive-pin readback for the mode control block.
// Assumes a recessive-high terminated bus and the bench clock.
`timescale 1ns/1ps
module cxm_bus_model (
  input  wire logic       clk,
  input  wire logic       tx_data,
  input  wire logic       tx_enable,
  input  wire logic       rx_out,
  input  wire logic [2:0] lag,
  input  wire logic       stuck_rec,
  input  wire logic       rx_stuck,
  input  wire logic       force_dom,
  output logic            bus_level,
  output logic            rx_sense
);
  logic [7:0] hist_r = 8'hff;
  // Driver history; a disabled driver leaves the bus to its termination
  always_ff @(posedge clk) begin
    hist_r <= {hist_r[6:0], tx_data | ~tx_enable};
  end
  // Lag picks a prompt or slow bus; another node may hold it dominant
  assign bus_level = ~force_dom & (stuck_rec | hist_r[lag]);
  // Readback clamp mimics a receive pin shorted recessive
  assign rx_sense = rx_stuck | rx_out;
endmodule

// file: test/cxm_ctrl_monitor.sv
// Port checker for the CAN transceiver mode control block.
// Assumes it is bound to cxm_ctrl and sees only its top-level ports.
`timescale 1ns/1ps
module cxm_ctrl_monitor #(
  parameter logic [15:0] T_RST_CYC = 16'd50
) (
  input wire logic                  CLK,
  input wire logic                  RST,
  input wire cxm_pkg::cxm_axi_req_s AXI_REQ,
  input wire cxm_pkg::cxm_axi_rsp_s AXI_RSP,
  input wire logic                  TX_DATA_IN,
  input wire logic                  BUS_RX,
  input wire logic                  RX_PIN_SENSE,
  input wire logic [7:0]            THERMAL_SHUTDOWN_FIRST_LEVEL,
  input wire logic                  COMM_TIMEOUT,
  input wire logic                  TX_ENABLE,
  input wire logic                  RX_ENABLE,
  input wire logic                  BIAS_ON,
  input wire logic                  RX_DATA_OUT,
  input wire logic                  WAKE_INT,
  input wire logic                  RESET_OUT_N
);
  // Margin covers input sync and the registered enable
  localparam int DOM_LIMIT = 3012;
  logic [15:0] tx_lo_r;
  logic [15:0] bus_lo_r;
  logic [15:0] rst_lo_r;
  // Run lengths of dominant inputs and of the reset pulse
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tx_lo_r  <= 16'h0;
      bus_lo_r <= 16'h0;
      rst_lo_r <= 16'h0;
    end else begin
      tx_lo_r  <= (TX_DATA_IN || !RX_ENABLE) ? 16'h0 : tx_lo_r + 16'h1;
      bus_lo_r <= BUS_RX ? 16'h0 : bus_lo_r + 16'h1;
      rst_lo_r <= RESET_OUT_N ? 16'h0 : rst_lo_r + 16'h1;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_woken;
    $rose(WAKE_INT);
  endsequence
  sequence s_rst_end;
    $rose(RESET_OUT_N);
  endsequence
  // Mode relations visible at the pins
  a_off_quiet: assert property (!RX_ENABLE |-> !TX_ENABLE && !BIAS_ON && RX_DATA_OUT)
    else $error("transceiver active while disabled");
  a_tx_full_func: assert property (TX_ENABLE |-> RX_ENABLE && BIAS_ON)
    else $error("transmitter on without receiver or bias");
  a_normal_no_int: assert property (TX_ENABLE |-> !WAKE_INT)
    else $error("interrupt raised while transmitting");
  a_stby_rx_rec: assert property ((WAKE_INT || !RESET_OUT_N) |-> RX_DATA_OUT && !TX_ENABLE)
    else $error("standby output not recessive");
  a_no_auto_normal: assert property (s_woken |-> !TX_ENABLE [*4])
    else $error("wake moved transceiver to normal");
  a_thermal_off: assert property ($rose(THERMAL_SHUTDOWN_FIRST_LEVEL[7]) |-> ##[1:8] !TX_ENABLE)
    else $error("global thermal did not stop transmitter");
  a_rx_kept_on: assert property (RX_ENABLE |=> RX_ENABLE)
    else $error("receiver switched off");
  a_tx_dom_timeout: assert property (tx_lo_r == DOM_LIMIT |-> !TX_ENABLE)
    else $error("dominant transmit input not timed out");
  a_wake_pulse_len: assert property (s_woken |-> bus_lo_r >= 16'd10)
    else $error("wake without filtered second pulse");
  a_rst_pulse_len: assert property (s_rst_end |-> rst_lo_r == T_RST_CYC)
    else $error("reset output pulse length wrong");
endmodule

// file: test/tb_top.sv
// Self-checking bench for the CAN transceiver mode control block.
// Assumes the design package and constants header are compiled first.
`timescale 1ns/1ps
`include "cxm_consts.svh"
module tb_top;
  localparam logic [15:0] RST_CYC = 16'd50;
  cxm_pkg::cxm_axi_req_s req;
  cxm_pkg::cxm_axi_rsp_s rsp;
  logic                  clk, rst, tx_in, bus_rx, rx_sense, comm_to, tx_en, rx_en, bias, rx_out;
  logic                  wake_int, rst_out_n, stuck_bus, stuck_rx, dom;
  logic [7:0]            therm;
  logic [2:0]            lag;
  int                    n_errors, num_checks, seed, n;
  // Bench clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  cxm_ctrl #(.T_WAKE_CYC(16'd200), .T_RST_CYC(RST_CYC)) u_dut (
    .CLK(clk), .RST(rst), .AXI_REQ(req), .AXI_RSP(rsp), .TX_DATA_IN(tx_in), .BUS_RX(bus_rx),
    .RX_PIN_SENSE(rx_sense), .THERMAL_SHUTDOWN_FIRST_LEVEL(therm), .COMM_TIMEOUT(comm_to),
    .TX_ENABLE(tx_en), .RX_ENABLE(rx_en), .BIAS_ON(bias), .RX_DATA_OUT(rx_out), .WAKE_INT(wake_int),
    .RESET_OUT_N(rst_out_n));
  cxm_bus_model u_bus (
    .clk(clk), .tx_data(tx_in), .tx_enable(tx_en), .rx_out(rx_out), .lag(lag), .stuck_rec(stuck_bus),
    .rx_stuck(stuck_rx), .force_dom(dom), .bus_level(bus_rx), .rx_sense(rx_sense));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge clk);
  endtask
  // Bus master: hold each channel until taken, bready until bvalid
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    k = 0;
    @(posedge clk);
    req <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: d, wstrb: 4'hf, bready: 1'b1, default: '0};
    do begin
      @(posedge clk);
      k++;
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1 && k < 100);
    req.bready <= 1'b0;
    if (k >= 100) n_errors++;
    chk(rsp.bresp, er);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int k;
    k = 0;
    @(posedge clk);
    req <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
    do begin
      @(posedge clk);
      k++;
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1 && k < 100);
    req.rready <= 1'b0;
    if (k >= 100) n_errors++;
    chk(rsp.rdata, e);
    chk(rsp.rresp, er);
  endtask
  // Random-length transmit frames; bus lag redrawn each dominant pulse
  task automatic pulses(input int k);
    repeat (k) begin
      lag <= 3'($unsigned($random(seed)) % 6);
      tx_in <= 1'b0;
      wt(25 + $unsigned($random(seed)) % 16);
      tx_in <= 1'b1;
      wt(25 + $unsigned($random(seed)) % 16);
    end
  endtask
  task automatic bus_pulse(input int d, input int r);
    dom <= 1'b1;
    wt(d);
    dom <= 1'b0;
    wt(r);
  endtask
  task automatic clr_status;
    axi_wr(`CXM_OFS_STATUS, 32'h1f, `CXM_RESP_OKAY);
    wt(8);
  endtask
  function automatic logic [31:0] exp_state(input logic [1:0] m, input logic t, input logic b);
    return {27'h0, b, 1'b1, t, m};
  endfunction
  task automatic final_report;
    if (n_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Watchdog sized well above the planned run
  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    final_report();
  end
  initial begin
    seed = 72579;
    n_errors = 0;
    num_checks = 0;
    rst = 1'b1;
    req = '0;
    {tx_in, comm_to, stuck_bus, stuck_rx, dom, lag, therm} = {1'b1, 15'h0};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    wt(4);
    chk(tx_en, 1'b0);
    axi_rd(`CXM_OFS_CTRL, 32'h40, `CXM_RESP_OKAY);
    axi_rd(8'h0c, 32'h0, `CXM_RESP_SLVERR);
    axi_wr(8'h0c, 32'hff, `CXM_RESP_SLVERR);
    axi_wr(`CXM_OFS_STATE, 32'hff, `CXM_RESP_OKAY);
    axi_rd(`CXM_OFS_STATE, 32'h0, `CXM_RESP_OKAY);
    axi_wr(`CXM_OFS_CTRL, 32'h41, `CXM_RESP_OKAY);
    wt(8);
    axi_rd(`CXM_OFS_STATE, exp_state(2'h1, 1'b1, 1'b1), `CXM_RESP_OKAY);
    pulses(30);
    axi_rd(`CXM_OFS_STATUS, 32'h0, `CXM_RESP_OKAY);
    // Three misses tolerated, the fourth latches; bus stuck also starves readback
    for (int k = 0; k < 2; k++) begin
      stuck_bus <= (k == 0);
      stuck_rx <= (k == 1);
      pulses(3);
      chk(tx_en, 1'b1);
      pulses(1);
      chk(rx_en, 1'b1);
      axi_rd(`CXM_OFS_STATUS, (k == 1) ? 32'h4 : 32'h6, `CXM_RESP_OKAY);
      stuck_bus <= 1'b0;
      stuck_rx <= 1'b0;
      pulses(1);
      chk(tx_en, 1'b0);
      clr_status();
      chk(tx_en, 1'b1);
    end
    tx_in <= 1'b0;
    wt(3100);
    chk(tx_en, 1'b0);
    tx_in <= 1'b1;
    axi_rd(`CXM_OFS_STATUS, 32'h1, `CXM_RESP_OKAY);
    chk(tx_en, 1'b0);
    clr_status();
    chk(tx_en, 1'b1);
    dom <= 1'b1;
    wt(4100);
    chk(tx_en, 1'b1);
    chk(rx_out, 1'b0);
    dom <= 1'b0;
    axi_rd(`CXM_OFS_STATUS, 32'h8, `CXM_RESP_OKAY);
    clr_status();
    axi_wr(`CXM_OFS_CTRL, 32'h49, `CXM_RESP_OKAY);
    bus_pulse(10, 0);
    chk(rx_out, 1'b0);
    chk(tx_en, 1'b0);
    axi_wr(`CXM_OFS_CTRL, 32'h59, `CXM_RESP_OKAY);
    for (int j = 0; j < 4; j++) begin
      tx_in <= j[0];
      wt(8);
      chk(rx_out, j[0]);
    end
    // Every thermal group under both group selections
    for (int g = 0; g < 16; g++) begin
      axi_wr(`CXM_OFS_CTRL, g[3] ? 32'h61 : 32'h41, `CXM_RESP_OKAY);
      therm <= 8'h1 << g[2:0];
      wt(8);
      chk(tx_en, g[3] && g[2:0] != 3'h7);
      therm <= 8'h0;
      wt(8);
      chk(tx_en, 1'b1);
    end
    for (int b = 0; b < 4; b++) begin
      comm_to <= b[1];
      axi_wr(`CXM_OFS_CTRL, 32'h40 | (32'(b[0]) << 2), `CXM_RESP_OKAY);
      wt(8);
      chk(bias, b == 1);
      axi_rd(`CXM_OFS_STATE, exp_state(2'h3, 1'b0, b == 1), `CXM_RESP_OKAY);
      chk(rx_out, 1'b1);
    end
    comm_to <= 1'b0;
    axi_wr(`CXM_OFS_CTRL, 32'h40, `CXM_RESP_OKAY);
    // Window runs out after one pulse, so the next pulse starts over
    bus_pulse(20, 250);
    bus_pulse(20, 15);
    chk(wake_int, 1'b0);
    bus_pulse(20, 8);
    chk(wake_int, 1'b1);
    chk(tx_en, 1'b0);
    axi_rd(`CXM_OFS_STATUS, 32'h10, `CXM_RESP_OKAY);
    clr_status();
    chk(wake_int, 1'b0);
    // Wake decoding off: a full pattern is ignored
    axi_wr(`CXM_OFS_CTRL, 32'h0, `CXM_RESP_OKAY);
    bus_pulse(20, 15);
    bus_pulse(20, 15);
    axi_rd(`CXM_OFS_STATUS, 32'h0, `CXM_RESP_OKAY);
    // Re-enabling wake-up holds off activation for the guard time
    axi_wr(`CXM_OFS_CTRL, 32'h41, `CXM_RESP_OKAY);
    wt(8);
    chk(tx_en, 1'b0);
    wt(1600);
    chk(tx_en, 1'b1);
    // Battery standby entered with the bus dominant
    dom <= 1'b1;
    wt(20);
    axi_wr(`CXM_OFS_CTRL, 32'h42, `CXM_RESP_OKAY);
    n = 0;
    fork
      begin
        bus_pulse(30, 15);
        bus_pulse(20, 15);
        bus_pulse(20, 15);
      end
      repeat (300) begin
        @(posedge clk);
        n = n + ((rst_out_n === 1'b0) ? 1 : 0);
      end
    join
    chk(n, RST_CYC);
    chk(wake_int, 1'b0);
    final_report();
  end
endmodule
bind cxm_ctrl cxm_ctrl_monitor #(.T_RST_CYC(T_RST_CYC)) u_mon (
  .CLK(CLK), .RST(RST), .AXI_REQ(AXI_REQ), .AXI_RSP(AXI_RSP), .TX_DATA_IN(TX_DATA_IN), .BUS_RX(BUS_RX),
  .RX_PIN_SENSE(RX_PIN_SENSE), .THERMAL_SHUTDOWN_FIRST_LEVEL(THERMAL_SHUTDOWN_FIRST_LEVEL),
  .COMM_TIMEOUT(COMM_TIMEOUT), .TX_ENABLE(TX_ENABLE), .RX_ENABLE(RX_ENABLE), .BIAS_ON(BIAS_ON),
  .RX_DATA_OUT(RX_DATA_OUT), .WAKE_INT(WAKE_INT), .RESET_OUT_N(RESET_OUT_N));
